// ==== rtl/spopc_regs.vh ====
// constants for the special-operations panel and program control block
// assumes instruction bit 0 is the msb of the 64-bit word
`ifndef SPOPC_REGS_VH
`define SPOPC_REGS_VH

// instruction word fields, lsb-based positions
`define SPOPC_GRP_HI 63
`define SPOPC_GRP_LO 61
`define SPOPC_GRP_SPECIAL 3'h1
`define SPOPC_SEL_HI 57
`define SPOPC_SEL_LO 54
`define SPOPC_SUB_HI 53
`define SPOPC_SUB_LO 50
`define SPOPC_IMM_HI 15
`define SPOPC_IMM_LO 0

// special selector codes
`define SPOPC_SEL_PANEL 4'h1
`define SPOPC_SEL_JUMP 4'h8
`define SPOPC_SEL_EVEN 4'h9
`define SPOPC_SEL_ODD 4'ha
`define SPOPC_SEL_HALF 4'hb
`define SPOPC_SEL_EXIT 4'hc

// pad bus word: exponent, mantissa high (00-11), mantissa low (12-27)
`define SPOPC_EXP_HI 37
`define SPOPC_EXP_LO 28
`define SPOPC_MH_HI 27
`define SPOPC_MH_LO 16
`define SPOPC_ML_HI 15
`define SPOPC_ML_LO 0

// program word: quarter 0 holds bits 00-15, i.e. the top lsb-based lane
`define SPOPC_Q_WIDTH 16
`define SPOPC_LH_LO 32
`define SPOPC_FP_HI 37

// partial-write restriction codes
`define SPOPC_RESTRICT_NONE 2'h0
`define SPOPC_RESTRICT_EXP 2'h1
`define SPOPC_RESTRICT_HIGH 2'h2
`define SPOPC_RESTRICT_LOW 2'h3

// apb register offsets and reset values
`define SPOPC_OFF_CTRL 12'h000
`define SPOPC_OFF_STATUS 12'h004
`define SPOPC_OFF_PANEL 12'h008
`define SPOPC_OFF_STACK 12'h00c
`define SPOPC_CTRL_RESET 32'h00000001
`define SPOPC_CTRL_RUN 0
`define SPOPC_PSA_RESET 16'h0000
`define SPOPC_SP_RESET 4'h0
`define SPOPC_LIGHTS_RESET 16'h0000

`endif

// ==== rtl/spopc_ret_stack.v ====
// return-address stack of sixteen entries with a wrapping pointer
// assumes push and set never coincide; the decoder guarantees it
`timescale 1ns/1ps
`include "spopc_regs.vh"
module spopc_ret_stack (
    input wire clk,
    input wire rstn,
    input wire push,
    input wire set,
    input wire [15:0] push_data,
    input wire [15:0] set_data,
    output reg [3:0] pointer,
    output wire [15:0] top
);
    reg [15:0] entry [0:15];
    wire [3:0] next_pointer;

    assign next_pointer = pointer + 4'h1;
    assign top = entry[pointer];

    // entries hold no reset; software must not trust them before a call
    always @(posedge clk) begin
        if (push) begin
            entry[next_pointer] <= push_data;
        end else if (set) begin
            entry[pointer] <= set_data;
        end
    end

    // pointer moves only on calls
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pointer <= `SPOPC_SP_RESET;
        end else if (push) begin
            pointer <= next_pointer;
        end
    end
endmodule // spopc_ret_stack

// ==== rtl/spopc_pm_lane.v ====
// lane steering between program words and the panel and pad buses
// assumes 64-bit program words, bit 00 at the msb
`timescale 1ns/1ps
`include "spopc_regs.vh"
module spopc_pm_lane (
    input wire half,
    input wire [1:0] quarter,
    input wire right,
    input wire [15:0] switch_data,
    input wire [37:0] pad_data,
    input wire [63:0] rdata,
    output wire [63:0] wdata,
    output wire [63:0] wmask,
    output wire [15:0] quarter_data,
    output wire [37:0] half_data
);
    wire [5:0] qshift;
    wire [63:0] qmask;
    wire [63:0] hmask;

    // quarter 0 is bits 00-15, quarter 3 bits 48-63
    assign qshift = {2'h3 - quarter, 4'h0};
    assign qmask = {48'h0, 16'hffff} << qshift;
    assign hmask = right ? 64'h00000000ffffffff : 64'hffffffff00000000;
    assign wmask = half ? hmask : qmask;
    assign wdata = half ? {pad_data[37:6], pad_data[31:0]}
                        : ({48'h0, switch_data} << qshift);
    assign quarter_data = rdata[qshift +: `SPOPC_Q_WIDTH];
    // left half sits on the top of the pad word; literal is bits 26-63
    assign half_data = right ? rdata[`SPOPC_FP_HI:0]
                             : {rdata[63:`SPOPC_LH_LO], 6'h0};
endmodule // spopc_pm_lane

// ==== rtl/spopc_top.v ====
// special-operations decoder: panel transfers, program address control,
// program-memory quarter and half transfers, exit setting
// assumes the control unit holds INSTR stable while ISSUE_HOLD is high
// and that program memory reads asynchronously from PM_ADDR
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "spopc_regs.vh"
module spopc_top (
    input wire CORE_CLK,
    input wire RSTN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire [63:0] INSTR,
    input wire INSTR_VALID,
    output wire ISSUE_HOLD,
    output wire TEST_INHIBIT,
    input wire [15:0] SWITCH_REGISTER,
    input wire [15:0] TABLE_MEMORY_ADDRESS,
    output reg [15:0] PANEL_BUS,
    output reg [15:0] PANEL_LIGHTS,
    input wire [37:0] PAD_BUS_IN,
    output reg [37:0] PAD_BUS_OUT,
    output reg PAD_BUS_OE,
    output reg [1:0] WRITE_RESTRICT,
    output wire [37:0] PAD_WRITE_MASK,
    output reg [15:0] PROGRAM_ADDRESS,
    output wire [3:0] RETURN_STACK_POINTER,
    output reg [15:0] PM_ADDR,
    output reg PM_RD,
    output reg PM_WR,
    output reg [63:0] PM_WDATA,
    output reg [63:0] PM_WMASK,
    input wire [63:0] PM_RDATA
);
    localparam ST_IDLE = 1'b0;
    localparam ST_XFER = 1'b1;

    reg state;
    reg next_state;
    reg [31:0] ctrl;
    reg [15:0] target;
    reg [15:0] next_lights;
    reg lights_load;

    wire [2:0] group;
    wire [3:0] special_selector;
    wire [3:0] sub;
    wire [15:0] imm;
    wire run;
    wire active;
    wire panel_op_field;
    wire program_address_field;
    wire even_quarter_field;
    wire odd_quarter_field;
    wire half_word_field;
    wire exit_set_field;
    wire quarter_op;
    wire pm_op;
    wire accept;
    wire jump;
    wire call;
    wire exit_set;
    wire [15:0] exit_value;
    wire [15:0] pm_target;
    wire [15:0] stack_top;
    wire [63:0] lane_wdata;
    wire [63:0] lane_wmask;
    wire [15:0] quarter_data;
    wire [37:0] half_data;
    wire apb_setup;
    wire apb_write;
    wire mapped;

    // address source: immediate, immediate plus program address,
    // table memory address, or the fourth source given by the caller
    function [15:0] addr_src;
        input [1:0] src;
        input [15:0] value;
        input [15:0] program_address;
        input [15:0] table_memory_address;
        input [15:0] alt;
        begin
            case (src)
                2'h0: addr_src = value;
                2'h1: addr_src = value + program_address;
                2'h2: addr_src = table_memory_address;
                default: addr_src = alt;
            endcase
        end
    endfunction

    // which pad bits a restricted write may touch
    function [37:0] restrict_mask;
        input [1:0] code;
        begin
            case (code)
                `SPOPC_RESTRICT_EXP: restrict_mask = {10'h3ff, 28'h0};
                `SPOPC_RESTRICT_HIGH: restrict_mask = {10'h0, 12'hfff, 16'h0};
                `SPOPC_RESTRICT_LOW: restrict_mask = {22'h0, 16'hffff};
                default: restrict_mask = {38{1'b1}};
            endcase
        end
    endfunction

    // instruction field decode
    assign group = INSTR[`SPOPC_GRP_HI:`SPOPC_GRP_LO];
    assign special_selector = INSTR[`SPOPC_SEL_HI:`SPOPC_SEL_LO];
    assign sub = INSTR[`SPOPC_SUB_HI:`SPOPC_SUB_LO];
    assign imm = INSTR[`SPOPC_IMM_HI:`SPOPC_IMM_LO];
    assign run = ctrl[`SPOPC_CTRL_RUN];
    assign active = INSTR_VALID & run & (group == `SPOPC_GRP_SPECIAL);

    assign panel_op_field = active & (special_selector == `SPOPC_SEL_PANEL);
    assign program_address_field = active & (special_selector == `SPOPC_SEL_JUMP);
    assign even_quarter_field = active & (special_selector == `SPOPC_SEL_EVEN);
    assign odd_quarter_field = active & (special_selector == `SPOPC_SEL_ODD);
    assign half_word_field = active & (special_selector == `SPOPC_SEL_HALF);
    assign exit_set_field = active & (special_selector == `SPOPC_SEL_EXIT);

    // no-load stays with the condition logic outside this block
    assign TEST_INHIBIT = program_address_field;

    // quarter codes 6, 7, 16, 17 are holes
    assign quarter_op = (even_quarter_field | odd_quarter_field)
                        & ~(sub[2] & sub[1]);
    assign pm_op = quarter_op | half_word_field;

    // first cycle holds issue, second cycle completes and retires
    assign ISSUE_HOLD = pm_op & (state == ST_IDLE);
    assign accept = INSTR_VALID & ~ISSUE_HOLD;

    // jump codes 10-17 are holes
    assign jump = accept & program_address_field & ~sub[3];
    assign call = jump & sub[0];
    // only odd exit codes below 10 do anything
    assign exit_set = accept & exit_set_field & sub[0] & ~sub[3];
    assign exit_value = addr_src(sub[2:1], imm, PROGRAM_ADDRESS,
                                 TABLE_MEMORY_ADDRESS,
                                 PROGRAM_ADDRESS + 16'h0001);
    // panel bus carries the switch register whenever nothing else drives it
    assign pm_target = addr_src(sub[2:1], imm, PROGRAM_ADDRESS,
                                TABLE_MEMORY_ADDRESS, SWITCH_REGISTER);

    always @* begin
        target = addr_src(sub[2:1], imm, PROGRAM_ADDRESS,
                          TABLE_MEMORY_ADDRESS, SWITCH_REGISTER);
    end

    // stack pointer moves on calls only, never on exit setting
    spopc_ret_stack u_stack (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .push(call),
        .set(exit_set),
        .push_data(PROGRAM_ADDRESS + 16'h0001),
        .set_data(exit_value),
        .pointer(RETURN_STACK_POINTER),
        .top(stack_top)
    );

    spopc_pm_lane u_lane (
        .half(half_word_field),
        .quarter({sub[0], odd_quarter_field}),
        .right(sub[0]),
        .switch_data(SWITCH_REGISTER),
        .pad_data(PAD_BUS_IN),
        .rdata(PM_RDATA),
        .wdata(lane_wdata),
        .wmask(lane_wmask),
        .quarter_data(quarter_data),
        .half_data(half_data)
    );

    // program address: jump target or the next word
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PROGRAM_ADDRESS <= `SPOPC_PSA_RESET;
        end else if (jump) begin
            PROGRAM_ADDRESS <= target;
        end else if (accept) begin
            PROGRAM_ADDRESS <= PROGRAM_ADDRESS + 16'h0001;
        end
    end

    // transfer sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (pm_op) begin
                    next_state = ST_XFER;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // memory request is launched from flops at the first edge and
    // stands for exactly the second cycle
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_IDLE;
            PM_ADDR <= 16'h0000;
            PM_RD <= 1'b0;
            PM_WR <= 1'b0;
            PM_WDATA <= 64'h0;
            PM_WMASK <= 64'h0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && pm_op) begin
                PM_ADDR <= pm_target;
                PM_RD <= ~sub[3];
                PM_WR <= sub[3];
                PM_WDATA <= lane_wdata;
                PM_WMASK <= lane_wmask;
            end else begin
                PM_RD <= 1'b0;
                PM_WR <= 1'b0;
            end
        end
    end

    // panel bus, pad bus and restriction for the executing instruction
    always @* begin
        PANEL_BUS = SWITCH_REGISTER;
        PAD_BUS_OUT = 38'h0;
        PAD_BUS_OE = 1'b0;
        WRITE_RESTRICT = `SPOPC_RESTRICT_NONE;
        lights_load = 1'b0;
        if (panel_op_field) begin
            case (sub)
                4'h0: lights_load = 1'b1;
                4'h1: begin
                    PANEL_BUS = {6'h0, PAD_BUS_IN[`SPOPC_EXP_HI:`SPOPC_EXP_LO]};
                    lights_load = 1'b1;
                end
                4'h2: begin
                    PANEL_BUS = {4'h0, PAD_BUS_IN[`SPOPC_MH_HI:`SPOPC_MH_LO]};
                    lights_load = 1'b1;
                end
                4'h3: begin
                    PANEL_BUS = PAD_BUS_IN[`SPOPC_ML_HI:`SPOPC_ML_LO];
                    lights_load = 1'b1;
                end
                4'h8: begin
                    PAD_BUS_OUT = {22'h0, SWITCH_REGISTER};
                    PAD_BUS_OE = 1'b1;
                end
                4'h9: begin
                    PAD_BUS_OUT[`SPOPC_EXP_HI:`SPOPC_EXP_LO] = SWITCH_REGISTER[9:0];
                    PAD_BUS_OE = 1'b1;
                    WRITE_RESTRICT = `SPOPC_RESTRICT_EXP;
                end
                4'ha: begin
                    PAD_BUS_OUT[`SPOPC_MH_HI:`SPOPC_MH_LO] = SWITCH_REGISTER[11:0];
                    PAD_BUS_OE = 1'b1;
                    WRITE_RESTRICT = `SPOPC_RESTRICT_HIGH;
                end
                4'hb: begin
                    PAD_BUS_OUT[`SPOPC_ML_HI:`SPOPC_ML_LO] = SWITCH_REGISTER;
                    PAD_BUS_OE = 1'b1;
                    WRITE_RESTRICT = `SPOPC_RESTRICT_LOW;
                end
                default: lights_load = 1'b0;
            endcase
        end else if (state == ST_XFER && PM_RD && quarter_op) begin
            PANEL_BUS = quarter_data;
            lights_load = 1'b1;
        end else if (state == ST_XFER && PM_RD && half_word_field) begin
            PAD_BUS_OUT = half_data;
            PAD_BUS_OE = 1'b1;
        end
    end

    assign PAD_WRITE_MASK = restrict_mask(WRITE_RESTRICT);

    // lights latch the panel bus; hold while issue is stalled
    always @* begin
        next_lights = PANEL_LIGHTS;
        if (lights_load && accept) begin
            next_lights = PANEL_BUS;
        end
    end

    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PANEL_LIGHTS <= `SPOPC_LIGHTS_RESET;
        end else begin
            PANEL_LIGHTS <= next_lights;
        end
    end

    // apb slave: zero wait states, error on unmapped offsets
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_write = PSEL & PENABLE & PWRITE;
    assign mapped = (PADDR == `SPOPC_OFF_CTRL) | (PADDR == `SPOPC_OFF_STATUS)
                    | (PADDR == `SPOPC_OFF_PANEL) | (PADDR == `SPOPC_OFF_STACK);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl <= `SPOPC_CTRL_RESET;
        end else if (apb_write && PADDR == `SPOPC_OFF_CTRL) begin
            ctrl <= {31'h0, PWDATA[`SPOPC_CTRL_RUN]};
        end
    end

    // read data is captured in the setup cycle, so it is a flop output
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h0;
        end else if (apb_setup) begin
            if (PADDR == `SPOPC_OFF_CTRL) begin
                PRDATA <= ctrl;
            end else if (PADDR == `SPOPC_OFF_STATUS) begin
                PRDATA <= {11'h0, state, RETURN_STACK_POINTER, PROGRAM_ADDRESS};
            end else if (PADDR == `SPOPC_OFF_PANEL) begin
                PRDATA <= {14'h0, WRITE_RESTRICT, PANEL_LIGHTS};
            end else if (PADDR == `SPOPC_OFF_STACK) begin
                PRDATA <= {16'h0, stack_top};
            end else begin
                PRDATA <= 32'h0;
            end
        end
    end
endmodule // spopc_top

// ==== sim/spopc_pm_model.sv ====
// program memory model: asynchronous read, masked write at the clock edge
// assumes one-cycle write pulses with a stable address
`timescale 1ns/1ps
module spopc_pm_model (
    input wire clk,
    input wire [15:0] addr,
    input wire rd,
    input wire wr,
    input wire [63:0] wdata,
    input wire [63:0] wmask,
    output wire [63:0] rdata
);
    reg [63:0] mem [0:255];
    // outside a read the bus shows garbage, never the last word
    assign rdata = rd ? mem[addr[7:0]] : ~mem[addr[7:0]];
    always @(posedge clk) begin
        if (wr) begin
            mem[addr[7:0]] <= (mem[addr[7:0]] & ~wmask) | (wdata & wmask);
        end
    end
endmodule // spopc_pm_model

// ==== sim/spopc_assertions.sv ====
// port checker for the special-operations decoder
// assumes the run bit stays set while instructions are presented
`timescale 1ns/1ps
module spopc_checker (
    input wire CORE_CLK,
    input wire RSTN,
    input wire [63:0] INSTR,
    input wire INSTR_VALID,
    input wire ISSUE_HOLD,
    input wire TEST_INHIBIT,
    input wire [15:0] SWITCH_REGISTER,
    input wire [15:0] PANEL_BUS,
    input wire [15:0] PANEL_LIGHTS,
    input wire [37:0] PAD_BUS_OUT,
    input wire PAD_BUS_OE,
    input wire [1:0] WRITE_RESTRICT,
    input wire [15:0] PROGRAM_ADDRESS,
    input wire [3:0] RETURN_STACK_POINTER,
    input wire PM_RD,
    input wire PM_WR
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    wire sp = INSTR_VALID && INSTR[63:61] == 3'h1;
    wire [3:0] sel = INSTR[57:54];
    wire [3:0] sub = INSTR[53:50];
    wire [15:0] imm = INSTR[15:0];
    wire go = sp && !ISSUE_HOLD;
    a_inhibit_jump: assert property (sp && sel == 4'h8 |-> TEST_INHIBIT)
        else $error("test not inhibited");
    a_hold_single: assert property (ISSUE_HOLD |=> !ISSUE_HOLD)
        else $error("hold too long");
    a_hold_access: assert property (ISSUE_HOLD |=> PM_RD || PM_WR)
        else $error("no memory access after hold");
    a_pm_pulse: assert property (PM_RD || PM_WR |=> !PM_RD && !PM_WR)
        else $error("memory strobe too long");
    a_exit_keeps: assert property (go && sel == 4'hc |=> $stable(RETURN_STACK_POINTER))
        else $error("exit moved pointer");
    a_call_push: assert property (go && sel == 4'h8 && sub < 4'h8 && sub[0]
        |=> RETURN_STACK_POINTER == $past(RETURN_STACK_POINTER) + 4'h1)
        else $error("call did not push");
    a_jump_abs: assert property (go && sel == 4'h8 && sub == 4'h0
        |=> PROGRAM_ADDRESS == $past(imm))
        else $error("jump target wrong");
    a_restrict_code: assert property (sp && sel == 4'h1 && sub > 4'h8 && sub < 4'hc
        |-> WRITE_RESTRICT == sub[1:0])
        else $error("restriction wrong");
    a_switch_pad: assert property (sp && sel == 4'h1 && sub == 4'h8
        |-> PAD_BUS_OE && PAD_BUS_OUT[15:0] == SWITCH_REGISTER)
        else $error("switches not on pad bus");
    a_lights_load: assert property (go && sel == 4'h1 && sub < 4'h4
        |=> PANEL_LIGHTS == $past(PANEL_BUS))
        else $error("lights not loaded");
    a_idle_sel: assert property (go && sel == 4'hf
        |=> $stable(RETURN_STACK_POINTER) && $stable(PANEL_LIGHTS))
        else $error("unassigned code changed state");
endmodule // spopc_checker
bind spopc_top spopc_checker chk_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .ISSUE_HOLD(ISSUE_HOLD), .TEST_INHIBIT(TEST_INHIBIT),
    .SWITCH_REGISTER(SWITCH_REGISTER), .PANEL_BUS(PANEL_BUS), .PANEL_LIGHTS(PANEL_LIGHTS),
    .PAD_BUS_OUT(PAD_BUS_OUT), .PAD_BUS_OE(PAD_BUS_OE), .WRITE_RESTRICT(WRITE_RESTRICT),
    .PROGRAM_ADDRESS(PROGRAM_ADDRESS), .RETURN_STACK_POINTER(RETURN_STACK_POINTER),
    .PM_RD(PM_RD), .PM_WR(PM_WR));

// ==== sim/tb_special_ops_panel_program_control.sv ====
// self-checking bench for the special-operations decoder
// assumes zero-wait apb and the program memory model on the pm port
`timescale 1ns/1ps
module tb_special_ops_panel_program_control;
    reg CORE_CLK = 1'b0;
    reg RSTN = 1'b0;
    reg PSEL = 1'b0;
    reg PENABLE = 1'b0;
    reg PWRITE = 1'b0;
    reg [11:0] PADDR = 12'h000;
    reg [31:0] PWDATA = 32'h0;
    reg [63:0] INSTR = 64'h0;
    reg INSTR_VALID = 1'b0;
    reg [15:0] SWITCH_REGISTER = 16'hb6d9;
    reg [15:0] TABLE_MEMORY_ADDRESS = 16'h0020;
    reg [37:0] PAD_BUS_IN = 38'h0;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, ISSUE_HOLD, TEST_INHIBIT, PAD_BUS_OE, PM_RD, PM_WR;
    wire [15:0] PANEL_BUS, PANEL_LIGHTS, PROGRAM_ADDRESS, PM_ADDR;
    wire [37:0] PAD_BUS_OUT, PAD_WRITE_MASK;
    wire [1:0] WRITE_RESTRICT;
    wire [3:0] RETURN_STACK_POINTER;
    wire [63:0] PM_WDATA, PM_WMASK, PM_RDATA;
    integer err_total = 0;
    integer n_tests = 0;
    integer cyc = 0;
    // bench copies of program address, stack pointer and current entry
    reg [15:0] program_address = 16'h0;
    reg [3:0] sp = 4'h0;
    reg [15:0] ent;
    reg held;
    reg [31:0] rd;
    reg er;
    spopc_top dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
        .ISSUE_HOLD(ISSUE_HOLD), .TEST_INHIBIT(TEST_INHIBIT),
        .SWITCH_REGISTER(SWITCH_REGISTER), .TABLE_MEMORY_ADDRESS(TABLE_MEMORY_ADDRESS),
        .PANEL_BUS(PANEL_BUS), .PANEL_LIGHTS(PANEL_LIGHTS), .PAD_BUS_IN(PAD_BUS_IN),
        .PAD_BUS_OUT(PAD_BUS_OUT), .PAD_BUS_OE(PAD_BUS_OE), .WRITE_RESTRICT(WRITE_RESTRICT),
        .PAD_WRITE_MASK(PAD_WRITE_MASK), .PROGRAM_ADDRESS(PROGRAM_ADDRESS),
        .RETURN_STACK_POINTER(RETURN_STACK_POINTER), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD),
        .PM_WR(PM_WR), .PM_WDATA(PM_WDATA), .PM_WMASK(PM_WMASK), .PM_RDATA(PM_RDATA));
    spopc_pm_model pm (.clk(CORE_CLK), .addr(PM_ADDR), .rd(PM_RD), .wr(PM_WR),
        .wdata(PM_WDATA), .wmask(PM_WMASK), .rdata(PM_RDATA));
    initial begin
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    task chk(input [63:0] got, input [63:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge CORE_CLK);
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= d;
            @(posedge CORE_CLK);
            PENABLE <= 1'b1;
            @(posedge CORE_CLK);
            while (PREADY !== 1'b1) @(posedge CORE_CLK);
            rd = PRDATA;
            er = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            @(negedge CORE_CLK);
        end
    endtask
    // leaves the caller in the retiring cycle, outputs settled
    task issue(input [3:0] s, input [3:0] c, input [15:0] v);
        begin
            @(posedge CORE_CLK);
            INSTR <= {3'h1, 3'h0, s, c, 34'h0, v};
            INSTR_VALID <= 1'b1;
            @(negedge CORE_CLK);
            held = ISSUE_HOLD;
            if (held === 1'b1) begin
                @(posedge CORE_CLK);
                @(negedge CORE_CLK);
            end
        end
    endtask
    task retire;
        begin
            @(posedge CORE_CLK);
            INSTR_VALID <= 1'b0;
            program_address = program_address + 16'h1;
            @(negedge CORE_CLK);
        end
    endtask
    task t_regs;
        begin
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, 32'h1);
            apb(1'b1, 12'h000, 32'h1);
            apb(1'b1, 12'h010, 32'hffffffff);
            chk(er, 1'b1);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, 12'h008, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    task t_jump;
        integer c;
        reg [15:0] t;
        begin
            for (c = 0; c < 8; c = c + 1) begin
                case (c / 2)
                    0: t = 16'h0140;
                    1: t = 16'h0140 + program_address;
                    2: t = TABLE_MEMORY_ADDRESS;
                    default: t = SWITCH_REGISTER;
                endcase
                issue(4'h8, c[3:0], 16'h0140);
                chk(TEST_INHIBIT, 1'b1);
                retire;
                if (c % 2 == 1) begin
                    sp = sp + 4'h1;
                    ent = program_address;
                    apb(1'b0, 12'h00c, 32'h0);
                    chk(rd[15:0], ent);
                end
                program_address = t;
                chk(PROGRAM_ADDRESS, program_address);
                chk(RETURN_STACK_POINTER, sp);
            end
        end
    endtask
    task t_exit;
        integer c;
        begin
            for (c = 0; c < 9; c = c + 1) begin
                case (c)
                    1: ent = 16'h0a51;
                    3: ent = 16'h0a51 + program_address;
                    5: ent = TABLE_MEMORY_ADDRESS;
                    7: ent = program_address + 16'h1;
                    default: ent = ent;
                endcase
                // last pass uses an unassigned selector
                issue(c == 8 ? 4'hf : 4'hc, c[3:0], 16'h0a51);
                retire;
                apb(1'b0, 12'h00c, 32'h0);
                chk(rd[15:0], ent);
                chk(RETURN_STACK_POINTER, sp);
            end
            chk(PROGRAM_ADDRESS, program_address);
        end
    endtask
    task t_panel;
        integer i;
        reg [3:0] c;
        reg [15:0] pb;
        reg [37:0] m;
        begin
            @(posedge CORE_CLK);
            PAD_BUS_IN <= {10'h2a5, 12'hc3f, 16'h1e78};
            for (i = 0; i < 8; i = i + 1) begin
                c = i[3:0] + (i < 4 ? 4'h0 : 4'h4);
                case (c)
                    1: pb = 16'h02a5;
                    2: pb = 16'h0c3f;
                    3: pb = 16'h1e78;
                    default: pb = SWITCH_REGISTER;
                endcase
                m = c == 4'h9 ? 38'h3ff0000000 : c == 4'ha ? 38'h000fff0000 : 38'h000000ffff;
                issue(4'h1, c, 16'h0);
                chk(PANEL_BUS, pb);
                chk(WRITE_RESTRICT, c[3] ? c[1:0] : 2'h0);
                if (c[3]) begin
                    chk(PAD_BUS_OE, 1'b1);
                    chk(PAD_BUS_OUT & m, {SWITCH_REGISTER[9:0], SWITCH_REGISTER[11:0],
                        SWITCH_REGISTER} & m);
                    if (c != 4'h8) chk(PAD_WRITE_MASK, m);
                end
                retire;
                if (!c[3]) chk(PANEL_LIGHTS, pb);
            end
        end
    endtask
    task t_quarter;
        integer q;
        reg [63:0] w;
        begin
            for (q = 0; q < 4; q = q + 1) begin
                @(posedge CORE_CLK);
                SWITCH_REGISTER <= 16'hc0d0 + q[15:0];
                issue(q[0] ? 4'ha : 4'h9, {3'h4, q[1]}, 16'h0020);
                chk(held, 1'b1);
                retire;
                w = {w[47:0], 16'hc0d0 + q[15:0]};
            end
            chk(pm.mem[8'h20], w);
            // first two addressed by table address, last two relative
            for (q = 0; q < 4; q = q + 1) begin
                issue(q[0] ? 4'ha : 4'h9, q[1] ? 4'h3 : 4'h4, 16'h0020 - program_address);
                chk(held, 1'b1);
                chk(PANEL_BUS, w[63 - 16 * q -: 16]);
                retire;
                chk(PANEL_LIGHTS, w[63 - 16 * q -: 16]);
            end
        end
    endtask
    task t_half;
        reg [63:0] w;
        begin
            @(posedge CORE_CLK);
            PAD_BUS_IN <= 38'h3a5a5ac3c3;
            issue(4'hb, 4'h8, 16'h0031);
            retire;
            issue(4'hb, 4'h9, 16'h0031);
            chk(held, 1'b1);
            retire;
            w = {PAD_BUS_IN[37:6], PAD_BUS_IN[31:0]};
            chk(pm.mem[8'h31], w);
            @(posedge CORE_CLK);
            SWITCH_REGISTER <= 16'h0031;
            issue(4'hb, 4'h6, 16'h0);
            chk(PAD_BUS_OE, 1'b1);
            chk(PAD_BUS_OUT, {w[63:32], 6'h0});
            retire;
            issue(4'hb, 4'h1, 16'h0031);
            chk(PAD_BUS_OUT, w[37:0]);
            retire;
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        @(negedge CORE_CLK);
        t_regs;
        t_jump;
        t_exit;
        t_panel;
        t_quarter;
        t_half;
        summarize;
    end
endmodule // tb_special_ops_panel_program_control
